// ==== inc/t1_ccp_pkg.sv ====
// Constants for the Timer1 buffered access and capture/compare routing block
//
// What this block does
// - Wide mode maps high address to buffer
// - Low byte read snapshots live high byte
// - Low byte write loads high from buffer
// - No direct live high access in wide mode
// - Low byte write or special event trigger clears prescaler
// - Secondary oscillator runs only when enabled
// - Oscillator keeps running in power-managed modes
// - Clock select 01 enters secondary run
// - Sleep with idle clear enters secondary idle
// - Status flag set while secondary clocks system
// - Low-power config bit selects oscillator power
// - Unit control and value halves read/write
// - Capture/compare use timer 1/3, PWM timer 2
// - Timer choice from t3 control enable bits
// - Both units may share one timer
// - No timer 1 capture when timer 1 asynchronous
// - Second unit pin select: port C1 or B3
// - Compare trigger resets unit's time base
// - Only second unit trigger starts conversion
// - Unit 2 uses timer 3 whenever unit 1 does
// - Both PWMs update on timer 2 period match
`default_nettype none

package t1_ccp_pkg;

	// Register addresses
	localparam logic [3:0] ADDR_T1_LOW = 4'h0;
	localparam logic [3:0] ADDR_T1_HIGH = 4'h1;
	localparam logic [3:0] ADDR_T1_CTRL = 4'h2;
	localparam logic [3:0] ADDR_T3_CTRL = 4'h3;
	localparam logic [3:0] ADDR_OSC_CTRL = 4'h4;
	localparam logic [3:0] ADDR_U1_CTRL = 4'h5;
	localparam logic [3:0] ADDR_U1_LOW = 4'h6;
	localparam logic [3:0] ADDR_U1_HIGH = 4'h7;
	localparam logic [3:0] ADDR_U2_CTRL = 4'h8;
	localparam logic [3:0] ADDR_U2_LOW = 4'h9;
	localparam logic [3:0] ADDR_U2_HIGH = 4'hA;
	localparam logic [3:0] ADDR_T3_LOW = 4'hB;
	localparam logic [3:0] ADDR_T3_HIGH = 4'hC;

	// t1_control fields
	localparam int T1_WIDE_BIT = 7;
	localparam int T1_SEC_ACTIVE_BIT = 6;
	localparam int T1_PS_LSB = 4;
	localparam int T1_OSC_EN_BIT = 3;
	localparam int T1_ASYNC_N_BIT = 2;
	localparam int T1_EXT_BIT = 1;
	localparam int T1_ON_BIT = 0;
	// t3_control fields: timer-to-unit enable bits and timer 3 on
	localparam int T3_SEL_HI_BIT = 6;
	localparam int T3_SEL_LO_BIT = 3;
	localparam int T3_ON_BIT = 0;
	// osc_control fields
	localparam int OSC_IDLE_BIT = 7;
	localparam int OSC_SCS_LSB = 0;
	localparam logic [1:0] SCS_SECONDARY = 2'h1;

	// Unit modes, low nibble of unit_control
	localparam logic [3:0] MODE_OFF = 4'h0;
	localparam logic [3:0] MODE_CAP_FIRST = 4'h4;
	localparam logic [3:0] MODE_CAP_LAST = 4'h7;
	localparam logic [3:0] MODE_CMP_SPECIAL = 4'hB;
	localparam logic [3:0] MODE_PWM_FIRST = 4'hC;

	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] OSC_RESET = 8'h00;

	typedef enum logic [1:0] {
		PM_PRIMARY,
		PM_SECONDARY_RUN_MODE,
		PM_SECONDARY_IDLE_MODE
	} power_mode_t;

endpackage

`default_nettype wire

// ==== hdl/t1_ccp_core.sv ====
// Timer1 with buffered 16-bit access, secondary oscillator control, unit routing
`timescale 1ns/1ps
`default_nettype none

module t1_ccp_core #(
	parameter int PWM_PERIOD_DEFAULT = 255
)(
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic sleep_i,
	input wire logic low_power_osc_config_i,
	input wire logic second_unit_pin_select_i,
	input wire logic sec_osc_ok_i,
	input wire logic ext_tick_i,
	input wire logic first_unit_capture_i,
	input wire logic second_unit_capture_i,
	output logic sec_osc_run_o,
	output logic sec_osc_low_power_o,
	output logic secondary_run_mode_o,
	output logic secondary_idle_mode_o,
	output logic adc_start_o,
	output logic first_unit_out_o,
	output logic port_c_pin_1_o,
	output logic port_b_pin_3_o,
	output logic pwm_update_o
);

	// Pins from outside pass two flops
	logic [3:0] pin_s1_q;
	logic [3:0] pin_s2_q;
	logic tick_prev_q;
	wire sleep_s = pin_s2_q[0];
	wire osc_ok_s = pin_s2_q[1];
	wire cap1_s = pin_s2_q[2];
	wire cap2_s = pin_s2_q[3];
	logic cap1_prev_q;
	logic cap2_prev_q;
	logic tick_s1_q;
	logic tick_s2_q;

	logic [7:0] t1_lo_q;
	logic [7:0] t1_hi_q;
	logic [7:0] t1_hbuf_q;
	logic [7:0] t1_ctrl_q;
	logic [7:0] t3_ctrl_q;
	logic [7:0] osc_ctrl_q;
	logic [15:0] t3_q;
	logic [7:0] t1_ps_q;
	logic [7:0] u1_ctrl_q;
	logic [7:0] u2_ctrl_q;
	logic [15:0] u1_val_q;
	logic [15:0] u2_val_q;
	logic [7:0] t2_q;
	logic [7:0] rdata_q;
	logic adc_q;
	logic u1_out_q;
	logic u2_out_q;
	logic pwm_upd_q;
	logic osc_run_q;
	logic osc_lp_q;
	logic run_q;
	logic idle_q;
	t1_ccp_pkg::power_mode_t pm_q;

	wire wide = t1_ctrl_q[t1_ccp_pkg::T1_WIDE_BIT];
	wire t1_on = t1_ctrl_q[t1_ccp_pkg::T1_ON_BIT];
	wire t1_async = ~t1_ctrl_q[t1_ccp_pkg::T1_ASYNC_N_BIT];
	wire osc_en = t1_ctrl_q[t1_ccp_pkg::T1_OSC_EN_BIT];
	wire [1:0] ps_sel = t1_ctrl_q[t1_ccp_pkg::T1_PS_LSB +: 2];
	wire [15:0] t1_val = {t1_hi_q, t1_lo_q};

	// Timer routing from t3_control enable bits
	wire sel_hi = t3_ctrl_q[t1_ccp_pkg::T3_SEL_HI_BIT];
	wire sel_lo = t3_ctrl_q[t1_ccp_pkg::T3_SEL_LO_BIT];
	wire u1_uses_t3 = sel_hi;
	wire u2_uses_t3 = sel_hi | sel_lo;

	wire [3:0] m1 = u1_ctrl_q[3:0];
	wire [3:0] m2 = u2_ctrl_q[3:0];
	wire u1_cap = m1 >= t1_ccp_pkg::MODE_CAP_FIRST
		&& m1 <= t1_ccp_pkg::MODE_CAP_LAST;
	wire u2_cap = m2 >= t1_ccp_pkg::MODE_CAP_FIRST
		&& m2 <= t1_ccp_pkg::MODE_CAP_LAST;
	wire u1_cmp = m1 > t1_ccp_pkg::MODE_CAP_LAST
		&& m1 < t1_ccp_pkg::MODE_PWM_FIRST;
	wire u2_cmp = m2 > t1_ccp_pkg::MODE_CAP_LAST
		&& m2 < t1_ccp_pkg::MODE_PWM_FIRST;
	wire u1_pwm = m1 >= t1_ccp_pkg::MODE_PWM_FIRST;
	wire u2_pwm = m2 >= t1_ccp_pkg::MODE_PWM_FIRST;
	wire u1_off = m1 == t1_ccp_pkg::MODE_OFF;
	wire u2_off = m2 == t1_ccp_pkg::MODE_OFF;

	// Capture/compare time base is timer 1 or 3
	wire [15:0] u1_base = u1_uses_t3 ? t3_q : t1_val;
	wire [15:0] u2_base = u2_uses_t3 ? t3_q : t1_val;
	wire u1_capok = u1_uses_t3 | ~t1_async;
	wire u2_capok = u2_uses_t3 | ~t1_async;
	wire cap1_ev = u1_cap & cap1_s & ~cap1_prev_q & u1_capok;
	wire cap2_ev = u2_cap & cap2_s & ~cap2_prev_q & u2_capok;
	wire u1_match = u1_cmp & (u1_base == u1_val_q);
	wire u2_match = u2_cmp & (u2_base == u2_val_q);
	wire u1_special = u1_match & (m1 == t1_ccp_pkg::MODE_CMP_SPECIAL);
	wire u2_special = u2_match & (m2 == t1_ccp_pkg::MODE_CMP_SPECIAL);
	// Special event resets whichever timer serves the unit
	wire t1_reset_ev = (u1_special & ~u1_uses_t3) | (u2_special & ~u2_uses_t3);
	wire t3_reset_ev = (u1_special & u1_uses_t3) | (u2_special & u2_uses_t3);

	// PWM period shared through timer 2
	wire t2_match = t2_q == 8'(PWM_PERIOD_DEFAULT);
	wire pwm_any = u1_pwm | u2_pwm;

	// Bus decode
	wire wr_lo = wr_i & (addr_i == t1_ccp_pkg::ADDR_T1_LOW);
	wire wr_hi = wr_i & (addr_i == t1_ccp_pkg::ADDR_T1_HIGH);
	wire rd_lo = rd_i & (addr_i == t1_ccp_pkg::ADDR_T1_LOW);
	wire wr_t1c = wr_i & (addr_i == t1_ccp_pkg::ADDR_T1_CTRL);
	wire wr_t3c = wr_i & (addr_i == t1_ccp_pkg::ADDR_T3_CTRL);
	wire wr_osc = wr_i & (addr_i == t1_ccp_pkg::ADDR_OSC_CTRL);
	wire wr_t3l = wr_i & (addr_i == t1_ccp_pkg::ADDR_T3_LOW);
	wire wr_t3h = wr_i & (addr_i == t1_ccp_pkg::ADDR_T3_HIGH);

	// Prescaler tick: internal clock or synchronised external input
	wire src_tick = t1_ctrl_q[t1_ccp_pkg::T1_EXT_BIT] ?
		(tick_s2_q & ~tick_prev_q) : 1'b1;
	wire [7:0] ps_mask = 8'((8'h01 << ps_sel) - 8'h01);
	wire ps_done = src_tick & ((t1_ps_q & ps_mask) == ps_mask);
	wire t1_inc = t1_on & ps_done;

	// Secondary clock is active when selected and the oscillator is good
	wire sec_active = osc_run_q & osc_ok_s & (pm_q != t1_ccp_pkg::PM_PRIMARY);
	wire [1:0] scs = osc_ctrl_q[t1_ccp_pkg::OSC_SCS_LSB +: 2];

	// Next power mode; the mode outputs are registered from it so they
	// leave flops directly and still change on the same edge as the state
	t1_ccp_pkg::power_mode_t pm_d;
	always_comb
	begin
		pm_d = pm_q;
		case (pm_q)
			t1_ccp_pkg::PM_PRIMARY:
				if (scs == t1_ccp_pkg::SCS_SECONDARY && osc_run_q)
					pm_d = t1_ccp_pkg::PM_SECONDARY_RUN_MODE;
			t1_ccp_pkg::PM_SECONDARY_RUN_MODE:
				if (scs != t1_ccp_pkg::SCS_SECONDARY || !osc_run_q)
					pm_d = t1_ccp_pkg::PM_PRIMARY;
				else if (sleep_s && !osc_ctrl_q[t1_ccp_pkg::OSC_IDLE_BIT])
					pm_d = t1_ccp_pkg::PM_SECONDARY_IDLE_MODE;
			// Waking from sleep returns to the secondary run mode
			t1_ccp_pkg::PM_SECONDARY_IDLE_MODE:
				if (!sleep_s)
					pm_d = t1_ccp_pkg::PM_SECONDARY_RUN_MODE;
			default:
				pm_d = t1_ccp_pkg::PM_PRIMARY;
		endcase
	end

	// Read mux; the high address shows the buffer in wide mode
	logic [7:0] rmux;
	always_comb
	begin
		case (addr_i)
			t1_ccp_pkg::ADDR_T1_LOW: rmux = t1_lo_q;
			t1_ccp_pkg::ADDR_T1_HIGH: rmux = wide ? t1_hbuf_q : t1_hi_q;
			t1_ccp_pkg::ADDR_T1_CTRL: rmux = {t1_ctrl_q[7], sec_active,
				t1_ctrl_q[5:0]};
			t1_ccp_pkg::ADDR_T3_CTRL: rmux = t3_ctrl_q;
			t1_ccp_pkg::ADDR_OSC_CTRL: rmux = osc_ctrl_q;
			t1_ccp_pkg::ADDR_U1_CTRL: rmux = u1_ctrl_q;
			t1_ccp_pkg::ADDR_U1_LOW: rmux = u1_val_q[7:0];
			t1_ccp_pkg::ADDR_U1_HIGH: rmux = u1_val_q[15:8];
			t1_ccp_pkg::ADDR_U2_CTRL: rmux = u2_ctrl_q;
			t1_ccp_pkg::ADDR_U2_LOW: rmux = u2_val_q[7:0];
			t1_ccp_pkg::ADDR_U2_HIGH: rmux = u2_val_q[15:8];
			t1_ccp_pkg::ADDR_T3_LOW: rmux = t3_q[7:0];
			t1_ccp_pkg::ADDR_T3_HIGH: rmux = t3_q[15:8];
			default: rmux = 8'h00;
		endcase
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			pin_s1_q <= 4'h0;
			pin_s2_q <= 4'h0;
			tick_s1_q <= 1'b0;
			tick_s2_q <= 1'b0;
			tick_prev_q <= 1'b0;
			cap1_prev_q <= 1'b0;
			cap2_prev_q <= 1'b0;
		end
		else
		begin
			pin_s1_q <= {second_unit_capture_i, first_unit_capture_i,
				sec_osc_ok_i, sleep_i};
			pin_s2_q <= pin_s1_q;
			tick_s1_q <= ext_tick_i;
			tick_s2_q <= tick_s1_q;
			tick_prev_q <= tick_s2_q;
			cap1_prev_q <= cap1_s;
			cap2_prev_q <= cap2_s;
		end
	end

	// Timer 1 counter, buffer and prescaler
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			t1_lo_q <= 8'h00;
			t1_hi_q <= 8'h00;
			t1_hbuf_q <= 8'h00;
			t1_ps_q <= 8'h00;
		end
		else
		begin
			if (wr_lo)
			begin
				t1_lo_q <= wdata_i;
				if (wide)
					t1_hi_q <= t1_hbuf_q;
				t1_ps_q <= 8'h00;
			end
			else if (t1_reset_ev)
			begin
				t1_lo_q <= 8'h00;
				t1_hi_q <= 8'h00;
				t1_ps_q <= 8'h00;
			end
			else
			begin
				if (src_tick)
					t1_ps_q <= ps_done ? 8'h00 : 8'(t1_ps_q + 8'h01);
				if (t1_inc)
					{t1_hi_q, t1_lo_q} <= 16'(t1_val + 16'h0001);
				if (wr_hi && !wide)
					t1_hi_q <= wdata_i;
			end
			// High writes touch only the buffer in wide mode
			if (wr_hi && wide)
				t1_hbuf_q <= wdata_i;
			else if (rd_lo && wide)
				t1_hbuf_q <= t1_hi_q;
		end
	end

	// Control registers, timer 3, units
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			t1_ctrl_q <= t1_ccp_pkg::CTRL_RESET;
			t3_ctrl_q <= t1_ccp_pkg::CTRL_RESET;
			osc_ctrl_q <= t1_ccp_pkg::OSC_RESET;
			u1_ctrl_q <= 8'h00;
			u2_ctrl_q <= 8'h00;
			u1_val_q <= 16'h0000;
			u2_val_q <= 16'h0000;
			t3_q <= 16'h0000;
		end
		else
		begin
			// Status bit is read-only, so writes skip bit 6
			if (wr_t1c)
				t1_ctrl_q <= wdata_i & ~(8'h01 << t1_ccp_pkg::T1_SEC_ACTIVE_BIT);
			if (wr_t3c)
				t3_ctrl_q <= wdata_i;
			if (wr_osc)
				osc_ctrl_q <= wdata_i;
			if (wr_i && addr_i == t1_ccp_pkg::ADDR_U1_CTRL)
				u1_ctrl_q <= wdata_i;
			if (wr_i && addr_i == t1_ccp_pkg::ADDR_U2_CTRL)
				u2_ctrl_q <= wdata_i;
			if (cap1_ev)
				u1_val_q <= u1_base;
			else if (wr_i && addr_i == t1_ccp_pkg::ADDR_U1_LOW)
				u1_val_q[7:0] <= wdata_i;
			else if (wr_i && addr_i == t1_ccp_pkg::ADDR_U1_HIGH)
				u1_val_q[15:8] <= wdata_i;
			if (cap2_ev)
				u2_val_q <= u2_base;
			else if (wr_i && addr_i == t1_ccp_pkg::ADDR_U2_LOW)
				u2_val_q[7:0] <= wdata_i;
			else if (wr_i && addr_i == t1_ccp_pkg::ADDR_U2_HIGH)
				u2_val_q[15:8] <= wdata_i;
			if (wr_t3l)
				t3_q[7:0] <= wdata_i;
			else if (wr_t3h)
				t3_q[15:8] <= wdata_i;
			else if (t3_reset_ev)
				t3_q <= 16'h0000;
			else if (t3_ctrl_q[t1_ccp_pkg::T3_ON_BIT])
				t3_q <= 16'(t3_q + 16'h0001);
		end
	end

	// Oscillator, power mode, unit outputs
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			pm_q <= t1_ccp_pkg::PM_PRIMARY;
			run_q <= 1'b0;
			idle_q <= 1'b0;
			osc_run_q <= 1'b0;
			osc_lp_q <= 1'b0;
			t2_q <= 8'h00;
			pwm_upd_q <= 1'b0;
			adc_q <= 1'b0;
			u1_out_q <= 1'b0;
			u2_out_q <= 1'b0;
			rdata_q <= 8'h00;
		end
		else
		begin
			rdata_q <= rd_i ? rmux : 8'h00;
			// Enable bit alone gates it; power mode never stops it
			osc_run_q <= osc_en;
			osc_lp_q <= low_power_osc_config_i;
			pm_q <= pm_d;
			run_q <= pm_d == t1_ccp_pkg::PM_SECONDARY_RUN_MODE;
			idle_q <= pm_d == t1_ccp_pkg::PM_SECONDARY_IDLE_MODE;
			t2_q <= (t2_match || !pwm_any) ? 8'h00 : 8'(t2_q + 8'h01);
			pwm_upd_q <= pwm_any & t2_match;
			adc_q <= u2_special;
			// Compare sets the pin; PWM uses the duty byte against timer 2
			if (u1_pwm)
				u1_out_q <= t2_q < u1_val_q[15:8];
			else if (u1_match)
				u1_out_q <= 1'b1;
			else if (u1_off)
				u1_out_q <= 1'b0;
			if (u2_pwm)
				u2_out_q <= t2_q < u2_val_q[15:8];
			else if (u2_match)
				u2_out_q <= 1'b1;
			else if (u2_off)
				u2_out_q <= 1'b0;
		end
	end

	// Second unit routing; pin direction stays software's job
	logic pc1_q;
	logic pb3_q;
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			pc1_q <= 1'b0;
			pb3_q <= 1'b0;
		end
		else
		begin
			pc1_q <= second_unit_pin_select_i & u2_out_q;
			pb3_q <= ~second_unit_pin_select_i & u2_out_q;
		end
	end

	assign rdata_o = rdata_q;
	assign sec_osc_run_o = osc_run_q;
	assign sec_osc_low_power_o = osc_lp_q;
	assign secondary_run_mode_o = run_q;
	assign secondary_idle_mode_o = idle_q;
	assign adc_start_o = adc_q;
	assign first_unit_out_o = u1_out_q;
	assign port_c_pin_1_o = pc1_q;
	assign port_b_pin_3_o = pb3_q;
	assign pwm_update_o = pwm_upd_q;

endmodule

`default_nettype wire

// ==== testbench/t1_ccp_core_properties.sv ====
// Port-level assertions for the timer1 block
`timescale 1ns/1ps
`default_nettype none

module t1_ccp_core_checker (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [3:0] addr_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic low_power_osc_config_i,
	input wire logic second_unit_pin_select_i,
	input wire logic sec_osc_run_o,
	input wire logic sec_osc_low_power_o,
	input wire logic secondary_run_mode_o,
	input wire logic secondary_idle_mode_o,
	input wire logic adc_start_o,
	input wire logic port_c_pin_1_o,
	input wire logic port_b_pin_3_o,
	input wire logic pwm_update_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);

	a_low_power_follow: assert property ($past(rstn_i) |->
		sec_osc_low_power_o == $past(low_power_osc_config_i))
		else $error("oscillator power level does not follow config");
	// Enable may land one or two edges after the write is taken
	a_osc_only_by_write: assert property ($changed(sec_osc_run_o) |->
		($past(wr_i) && $past(addr_i) == t1_ccp_pkg::ADDR_T1_CTRL) ||
		($past(wr_i, 2) && $past(addr_i, 2) == t1_ccp_pkg::ADDR_T1_CTRL))
		else $error("oscillator enable changed without a control write");
	a_read_data_idle: assert property (!$past(rd_i) |->
		rdata_o == 8'h00) else $error("read data outside its cycle");
	a_mode_exclusive: assert property
		(!(secondary_run_mode_o && secondary_idle_mode_o))
		else $error("run and idle modes both active");
	a_osc_kept_idle: assert property ($rose(secondary_idle_mode_o) |->
		sec_osc_run_o == $past(sec_osc_run_o))
		else $error("idle entry changed the oscillator");
	a_pin_c_route: assert property
		(second_unit_pin_select_i && $past(second_unit_pin_select_i) |->
		!port_b_pin_3_o) else $error("unselected pin b driven");
	a_pin_b_route: assert property
		(!second_unit_pin_select_i && !$past(second_unit_pin_select_i) |->
		!port_c_pin_1_o) else $error("unselected pin c driven");
	a_adc_single: assert property (adc_start_o |=> !adc_start_o)
		else $error("conversion start longer than one cycle");
	a_update_single: assert property (pwm_update_o |=> !pwm_update_o)
		else $error("period update longer than one cycle");
endmodule

bind t1_ccp_core t1_ccp_core_checker u_t1_ccp_core_checker (
	.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wr_i(wr_i),
	.rd_i(rd_i), .rdata_o(rdata_o),
	.low_power_osc_config_i(low_power_osc_config_i),
	.second_unit_pin_select_i(second_unit_pin_select_i),
	.sec_osc_run_o(sec_osc_run_o), .sec_osc_low_power_o(sec_osc_low_power_o),
	.secondary_run_mode_o(secondary_run_mode_o),
	.secondary_idle_mode_o(secondary_idle_mode_o),
	.adc_start_o(adc_start_o), .port_c_pin_1_o(port_c_pin_1_o),
	.port_b_pin_3_o(port_b_pin_3_o), .pwm_update_o(pwm_update_o)
);

`default_nettype wire

// ==== testbench/cpu_bus_model.sv ====
// Processor-side register bus master
`timescale 1ns/1ps
`default_nettype none

module cpu_bus_model (
	input wire logic clk_i,
	input wire logic [7:0] rdata_i,
	output logic [3:0] addr_o,
	output logic [7:0] wdata_o,
	output logic wr_o,
	output logic rd_o
);
	initial
	begin
		addr_o <= 4'h0;
		wdata_o <= 8'h00;
		wr_o <= 1'b0;
		rd_o <= 1'b0;
	end

	// A spare edge after each strobe keeps a strobe from being set twice at once
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		@(posedge clk_i);
		d = rdata_i;
	endtask
endmodule

`default_nettype wire

// ==== testbench/t1_ccp_core_test.sv ====
// Self-checking bench for the timer1 block
`timescale 1ns/1ps
`default_nettype none
`define CHECK(a, e) begin n_tests++; if ((a) !== (e)) begin num_errors++; \
	$display("Error at %0t: got %h want %h", $time, a, e); end end

module t1_ccp_core_test;
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic sleep_i = 1'b0;
	logic lp_cfg = 1'b0;
	logic pin_sel = 1'b1; // Pin direction stays with software
	logic cap1 = 1'b0;
	logic cap2 = 1'b0;
	logic osc_ok = 1'b0;
	logic tie0 = 1'b0;
	logic [3:0] addr;
	logic [7:0] wdata, rdata;
	logic wr, rd, osc_run, osc_lp, run_m, idle_m, adc, u1_out, pc1, pb3, upd;
	int num_errors = 0;
	int n_tests = 0;
	int cycles = 0;

	t1_ccp_core #(.PWM_PERIOD_DEFAULT(7)) u_t1_ccp_core (
		.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdata), .sleep_i(sleep_i),
		.low_power_osc_config_i(lp_cfg), .second_unit_pin_select_i(pin_sel),
		.sec_osc_ok_i(osc_ok), .ext_tick_i(tie0), .first_unit_capture_i(cap1),
		.second_unit_capture_i(cap2), .sec_osc_run_o(osc_run),
		.sec_osc_low_power_o(osc_lp), .secondary_run_mode_o(run_m),
		.secondary_idle_mode_o(idle_m), .adc_start_o(adc),
		.first_unit_out_o(u1_out), .port_c_pin_1_o(pc1),
		.port_b_pin_3_o(pb3), .pwm_update_o(upd));
	cpu_bus_model u_cpu_bus_model (.clk_i(clk_i), .rdata_i(rdata),
		.addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));

	always #2.5 clk_i = ~clk_i;

	task automatic finish_test;
		$display("Errors %0d, checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			num_errors++;
			finish_test();
		end
	end

	task automatic wreg(input logic [3:0] a, input logic [7:0] v);
		u_cpu_bus_model.wr_reg(a, v);
	endtask
	task automatic rreg(input logic [3:0] a, output logic [7:0] v);
		u_cpu_bus_model.rd_reg(a, v);
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	task automatic test_regs;
		logic [7:0] v;
		rreg(t1_ccp_pkg::ADDR_T1_CTRL, v);
		`CHECK(v, t1_ccp_pkg::CTRL_RESET)
		rreg(4'hF, v);
		`CHECK(v, 8'h00)
		for (int a = 5; a <= 10; a++)
		begin
			wreg(4'(a), {4'(a), 4'h0});
			rreg(4'(a), v);
			`CHECK(v, {4'(a), 4'h0})
		end
	endtask

	// Counter stopped so every byte is exact
	task automatic test_wide;
		logic [7:0] v;
		wreg(4'h2, 8'h80);
		wreg(4'h1, 8'hAB);
		wreg(4'h0, 8'hCD);
		rreg(4'h0, v);
		`CHECK(v, 8'hCD)
		rreg(4'h1, v);
		`CHECK(v, 8'hAB)
		wreg(4'h1, 8'h55);
		rreg(4'h0, v);
		rreg(4'h1, v);
		`CHECK(v, 8'hAB)
		wreg(4'h2, 8'h00);
		rreg(4'h1, v);
		`CHECK(v, 8'hAB)
		wreg(4'h1, 8'h77);
		rreg(4'h1, v);
		`CHECK(v, 8'h77)
	endtask

	task automatic test_wrap;
		logic [7:0] v;
		wreg(4'h1, 8'hFF);
		wreg(4'h0, 8'hF0);
		wreg(4'h2, 8'h01);
		idle(20);
		wreg(4'h2, 8'h00);
		rreg(4'h1, v);
		`CHECK(v, 8'h00)
		rreg(4'h0, v);
		`CHECK(v < 8'h30, 1'b1)
	endtask

	task automatic test_osc;
		logic [7:0] v;
		idle(2);
		`CHECK(osc_run, 1'b0)
		wreg(4'h2, 8'h08);
		idle(2);
		`CHECK(osc_run, 1'b1)
		osc_ok <= 1'b1;
		wreg(4'h4, 8'h01);
		idle(2);
		`CHECK(run_m, 1'b1)
		rreg(4'h2, v);
		`CHECK(v[6], 1'b1)
		sleep_i <= 1'b1;
		idle(6);
		`CHECK(idle_m, 1'b1)
		`CHECK(osc_run, 1'b1)
		sleep_i <= 1'b0;
		idle(6);
		osc_ok <= 1'b0;
		idle(4);
		rreg(4'h2, v);
		`CHECK(v[6], 1'b0)
		wreg(4'h4, 8'h00);
		wreg(4'h2, 8'h00);
		lp_cfg <= 1'b1;
		idle(3);
		`CHECK(osc_lp, 1'b1)
		`CHECK(osc_run, 1'b0)
		lp_cfg <= 1'b0;
	endtask

	task automatic watch(output int c, output int b, output int f);
		c = 0;
		b = 0;
		f = 0;
		repeat (64)
		begin
			@(posedge clk_i);
			c += pc1;
			b += pb3;
			f += u1_out;
		end
	endtask

	task automatic test_pwm;
		int c, b, f, n;
		wreg(4'h7, 8'h03);
		wreg(4'hA, 8'h03);
		wreg(4'h5, 8'h0C);
		wreg(4'h8, 8'h0C);
		idle(20);
		watch(c, b, f);
		`CHECK(b, 0)
		`CHECK(c, 24)
		`CHECK(f, c)
		n = 0;
		repeat (64)
		begin
			@(posedge clk_i);
			n += upd;
		end
		`CHECK(n, 8)
		pin_sel <= 1'b0;
		idle(4);
		watch(c, b, f);
		`CHECK(c, 0)
		`CHECK(b, f)
		pin_sel <= 1'b1;
		wreg(4'h5, 8'h00);
		wreg(4'h8, 8'h00);
	endtask

	// Both compare units use timer 1, which must never pass the match value
	task automatic test_trig;
		logic [7:0] v;
		int n;
		wreg(4'h3, 8'h00);
		wreg(4'h9, 8'h10);
		wreg(4'hA, 8'h00);
		wreg(4'h8, 8'h0B);
		wreg(4'h2, 8'h01);
		n = 0;
		while (adc !== 1'b1 && n < 300)
		begin
			@(posedge clk_i);
			n++;
		end
		`CHECK(adc, 1'b1)
		rreg(4'h0, v);
		`CHECK(v < 8'h12, 1'b1)
		wreg(4'h8, 8'h00);
		wreg(4'h6, 8'h10);
		wreg(4'h7, 8'h00);
		wreg(4'h5, 8'h0B);
		n = 0;
		repeat (100)
		begin
			@(posedge clk_i);
			n += adc;
		end
		`CHECK(n, 0)
		rreg(4'h0, v);
		`CHECK(v < 8'h12, 1'b1)
		wreg(4'h5, 8'h00);
		wreg(4'h2, 8'h00);
	endtask

	task automatic pulse_caps;
		cap1 <= 1'b1;
		cap2 <= 1'b1;
		idle(4);
		cap1 <= 1'b0;
		cap2 <= 1'b0;
		idle(4);
	endtask

	// Both timers stopped, so each capture holds an exact time base value
	task automatic test_capture;
		logic [7:0] v;
		wreg(4'h3, 8'h08);
		wreg(4'hB, 8'h22);
		wreg(4'hC, 8'h33);
		wreg(4'h2, 8'h04);
		wreg(4'h1, 8'h11);
		wreg(4'h0, 8'h44);
		wreg(4'h5, 8'h04);
		wreg(4'h8, 8'h04);
		pulse_caps();
		rreg(4'h6, v);
		`CHECK(v, 8'h44)
		rreg(4'h7, v);
		`CHECK(v, 8'h11)
		rreg(4'h9, v);
		`CHECK(v, 8'h22)
		rreg(4'hA, v);
		`CHECK(v, 8'h33)
		wreg(4'h2, 8'h00);
		wreg(4'h0, 8'h55);
		wreg(4'hB, 8'h66);
		pulse_caps();
		rreg(4'h6, v);
		`CHECK(v, 8'h44)
		rreg(4'h9, v);
		`CHECK(v, 8'h66)
		wreg(4'h5, 8'h00);
		wreg(4'h8, 8'h00);
		wreg(4'h3, 8'h00);
	endtask

	initial
	begin
		idle(20);
		rstn_i <= 1'b1;
		idle(2);
		test_regs();
		test_wide();
		test_wrap();
		test_osc();
		test_pwm();
		test_trig();
		test_capture();
		finish_test();
	end
endmodule

`default_nettype wire
